// ### tsfm_map.svh
`ifndef TSFM_MAP_SVH
`define TSFM_MAP_SVH
`define TSFM_NUM_CH 18
`define TSFM_CLK_PERIOD_NS 100
`define TSFM_MS_NS 1000000
`define TSFM_CLKS_PER_MS (`TSFM_MS_NS / `TSFM_CLK_PERIOD_NS)
`define TSFM_MS_W 11
`define TSFM_FIELD_ON_MS 500
`define TSFM_SF_ON_MS 550
`define TSFM_RF_EXT_MS 1350
`define TSFM_RF_LEG_MS 850
`define TSFM_WD_ON_MS 1000
`define TSFM_WD_OFF_MS 1500
`define TSFM_BO_ON_MS 400
`define TSFM_BO_OFF_MS 80
`define TSFM_REG_CTRL 8'h00
`define TSFM_REG_FAULT 8'h04
`define TSFM_REG_FAIL_CH 8'h08
`define TSFM_REG_CAP_RED 8'h0C
`define TSFM_REG_CAP_YEL 8'h10
`define TSFM_REG_CAP_GRN 8'h14
`define TSFM_REG_RF_MASK 8'h18
`define TSFM_RF_MASK_RST 18'h3FFFF
`define TSFM_CTRL_RESET 0
`define TSFM_NUM_FLT 9
`define TSFM_FLT_CARD 0
`define TSFM_FLT_CABLE 1
`define TSFM_FLT_RF 2
`define TSFM_FLT_WD 3
`define TSFM_FLT_CONF 4
`define TSFM_FLT_DUAL 5
`define TSFM_FLT_CLR 6
`define TSFM_FLT_DC 7
`define TSFM_FLT_DIAG 8
`define TSFM_RESP_OKAY 2'h0
`define TSFM_RESP_SLVERR 2'h2
`endif

// ### tsfm_pkg.sv
`include "tsfm_map.svh"
package tsfm_pkg;
  typedef struct packed {
    logic power;
    logic dc_fail;
    logic watchdog;
    logic conflict;
    logic red_fail;
    logic dual;
    logic clearance;
    logic card_ajar;
    logic diag;
  } tsfm_ind_type;
  typedef struct packed {
    logic [`TSFM_NUM_CH-1:0] red;
    logic [`TSFM_NUM_CH-1:0] yel;
    logic [`TSFM_NUM_CH-1:0] grn;
  } tsfm_lamp_type;
  typedef struct packed {
    logic rf_ext;
    logic wd_short;
    logic bo_long;
    logic wd_latch;
    logic relay_inv;
  } tsfm_opt_type;
endpackage

// ### tsfm_tick.sv
`timescale 1ns/10ps
module tsfm_tick #(
  parameter int CLKS_PER_MS = 10000
) (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  output logic      tick_o
);
  logic [15:0] cnt;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cnt    <= 16'h0000;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      tick_o <= (cnt == 16'(CLKS_PER_MS - 1));
      cnt    <= (cnt == 16'(CLKS_PER_MS - 1)) ? 16'h0000 : cnt + 16'h0001;
    end
  end
endmodule

// ### tsfm_qual.sv
`timescale 1ns/10ps
module tsfm_qual #(
  parameter int N     = 1,
  parameter int ON_MS = 500
) (
  input  wire logic         clock_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic         tick_i,
  input  wire logic [N-1:0] raw_i,
  output logic      [N-1:0] on_o
);
  logic [9:0] cnt [N];
  for (genvar k = 0; k < N; k++) begin : g_ch
    // off at once on release, on after ON_MS of continuous assertion
    always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
        cnt[k]  <= 10'h000;
        on_o[k] <= 1'b0;
      end else if (ce_i) begin
        if (!raw_i[k]) begin
          cnt[k]  <= 10'h000;
          on_o[k] <= 1'b0;
        end else if (tick_i && cnt[k] != 10'(ON_MS)) begin
          cnt[k]  <= cnt[k] + 10'h001;
          on_o[k] <= (cnt[k] == 10'(ON_MS - 1));
        end
      end
    end
  end
endmodule

// ### tsfm_monitor.sv
// Summary of operation
// [RQ1] eighteen channels, each with qualified red, yellow and green inputs
// [RQ2] missing program card latches a fault until card back and reset
// [RQ3] fault entry captures failed or active channels and all lamp states
// [RQ4] nine indicators plus 54 per-channel red, yellow, green lamps
// [RQ5] red-fail time 1350 ms when option on, 850 ms when off
// [RQ6] watchdog time 1.0 s when option on, 1.5 s when off
// [RQ7] brown-out time 400 ms when option set, 80 ms when clear
// [RQ8] latch option off: power events clear a watchdog fault
// [RQ9] latch option on: watchdog fault held until reset command
// [RQ10] polarity option inverts the active sense of relay common
// [RQ11] red interface cable removal latches a fault and forces flash
// [RQ12] an active special function suppresses only red-fail monitoring
// [RQ13] special function active after 550 ms asserted, off under 250 ms
// [RQ14] red input on after 500 ms asserted, off under 200 ms
// [RQ15] green or yellow on after 500 ms asserted, off under 200 ms
// [RQ16] faults held until front-panel or remote reset
// [RQ17] channel with no indication past the red-fail time trips and flashes
// [RQ18] per-channel red-fail enable selects which channels are checked
// [RQ19] red-fail needs red enable active and no special function
// [RQ20] red-fail also needs relay common not active
// [RQ21] inputs are synchronous levels, durations counted in 1 ms ticks
`timescale 1ns/10ps
`include "tsfm_map.svh"
module tsfm_monitor #(
  parameter int CLKS_PER_MS = `TSFM_CLKS_PER_MS
) (
  // clock, reset, enable
  input  wire logic                    clock_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    ce_i,
  // field inputs
  input  wire logic [`TSFM_NUM_CH-1:0] red_i,
  input  wire logic [`TSFM_NUM_CH-1:0] yel_i,
  input  wire logic [`TSFM_NUM_CH-1:0] grn_i,
  input  wire logic [1:0]              special_func_i,
  input  wire logic                    red_enable_i,
  input  wire logic                    relay_common_input_i,
  input  wire logic                    watchdog_timer_i,
  // cabinet and option inputs
  input  wire logic [`TSFM_NUM_CH-1:0] rf_enable_i,
  input  wire tsfm_pkg::tsfm_opt_type  opt_i,
  input  wire logic                    card_present_i,
  input  wire logic                    red_interface_cable_i,
  input  wire logic                    ac_low_i,
  input  wire logic                    power_restore_i,
  input  wire logic                    dc_supply_failure_i,
  input  wire logic                    conflict_i,
  input  wire logic                    dual_fail_i,
  input  wire logic                    clear_fail_i,
  input  wire logic                    diag_fail_i,
  input  wire logic                    front_reset_i,
  input  wire logic                    remote_reset_i,
  // indicators and cabinet control
  output tsfm_pkg::tsfm_ind_type       ind_o,
  output tsfm_pkg::tsfm_lamp_type      lamp_o,
  output logic                         force_flash_o,
  // axi4-lite slave
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready
);
  localparam int NC = `TSFM_NUM_CH;
  localparam int MW = `TSFM_MS_W;
  localparam int NF = `TSFM_NUM_FLT;

  function automatic logic [MW-1:0] sel_ms(input logic on, input int a, input int b);
    return on ? MW'(a) : MW'(b);
  endfunction

  function automatic logic is_reg(input logic [7:0] a);
    return a <= `TSFM_REG_RF_MASK && a[1:0] == 2'b00;
  endfunction

  logic                tick;
  logic [NC-1:0]       red_q;
  logic [NC-1:0]       yel_q;
  logic [NC-1:0]       grn_q;
  logic [1:0]          sf_q;
  logic                ren_q;
  logic [MW-1:0]       rf_cnt [NC];
  logic [NC-1:0]       rf_trip;
  logic [NC-1:0]       fail_ch;
  logic [NC-1:0]       rf_mask;
  logic [NF-1:0]       flt;
  logic [NF-1:0]       flt_set;
  logic [NF-1:0]       flt_clr;
  logic                fault_mode;
  logic                fault_mode_d;
  tsfm_pkg::tsfm_lamp_type cap;
  logic [MW-1:0]       wd_cnt;
  logic                wd_prev;
  logic                wd_trip;
  logic [MW-1:0]       bo_cnt;
  logic                brownout;
  logic                power_event;
  logic                relay_active;
  logic                rf_run;
  logic                sw_reset;
  logic                rst_cmd;
  logic [MW-1:0]       rf_lim;
  logic [MW-1:0]       wd_lim;
  logic [MW-1:0]       bo_lim;
  logic                aw_held;
  logic                w_held;
  logic [7:0]          aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                do_write;

  tsfm_tick #(.CLKS_PER_MS(CLKS_PER_MS)) u_tick (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .tick_o  (tick)                                             // [RQ21]
  );

  tsfm_qual #(.N(3 * NC + 1), .ON_MS(`TSFM_FIELD_ON_MS)) u_field (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .tick_i  (tick),
    .raw_i   ({red_enable_i, grn_i, yel_i, red_i}),             // [RQ1] [RQ14] [RQ15]
    .on_o    ({ren_q, grn_q, yel_q, red_q})
  );

  tsfm_qual #(.N(2), .ON_MS(`TSFM_SF_ON_MS)) u_sf (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .tick_i  (tick),
    .raw_i   (special_func_i),                                  // [RQ13]
    .on_o    (sf_q)
  );

  assign relay_active = relay_common_input_i ^ opt_i.relay_inv;  // [RQ10]
  assign rf_run = ren_q && !(|sf_q) && !relay_active;           // [RQ12] [RQ19] [RQ20]
  assign rf_lim = sel_ms(opt_i.rf_ext, `TSFM_RF_EXT_MS, `TSFM_RF_LEG_MS);  // [RQ5]
  assign wd_lim = sel_ms(opt_i.wd_short, `TSFM_WD_ON_MS, `TSFM_WD_OFF_MS); // [RQ6]
  assign bo_lim = sel_ms(opt_i.bo_long, `TSFM_BO_ON_MS, `TSFM_BO_OFF_MS);  // [RQ7]
  assign rst_cmd = front_reset_i || remote_reset_i || sw_reset; // [RQ16]
  assign fault_mode = |flt;

  // red-fail gap timers, one per channel
  for (genvar k = 0; k < NC; k++) begin : g_rf
    assign rf_trip[k] = rf_cnt[k] >= rf_lim;
    always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
        rf_cnt[k] <= '0;
      end else if (ce_i) begin
        if (!rf_run || !rf_enable_i[k] || !rf_mask[k] ||
            red_q[k] || yel_q[k] || grn_q[k]) begin           // [RQ18] [RQ17]
          rf_cnt[k] <= '0;
        end else if (tick && !rf_trip[k]) begin
          rf_cnt[k] <= rf_cnt[k] + MW'(1);
        end
      end
    end
  end

  // watchdog: time since last input transition
  assign wd_trip = wd_cnt >= wd_lim;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wd_cnt  <= '0;
      wd_prev <= 1'b0;
    end else if (ce_i) begin
      wd_prev <= watchdog_timer_i;
      if (watchdog_timer_i != wd_prev || power_event) begin
        wd_cnt <= '0;
      end else if (tick && !wd_trip) begin
        wd_cnt <= wd_cnt + MW'(1);
      end
    end
  end

  // brown-out: low line held for the option time, event on restore
  assign power_event = power_restore_i || (brownout && !ac_low_i);
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      bo_cnt   <= '0;
      brownout <= 1'b0;
    end else if (ce_i) begin
      if (!ac_low_i) begin
        bo_cnt   <= '0;
        brownout <= 1'b0;
      end else if (tick && bo_cnt < bo_lim) begin
        bo_cnt <= bo_cnt + MW'(1);
      end else if (bo_cnt >= bo_lim) begin
        brownout <= 1'b1;                                       // [RQ7]
      end
    end
  end

  // latched faults: a new cause wins over any clear
  always_comb begin
    flt_set = '0;
    flt_set[`TSFM_FLT_CARD]  = !card_present_i;                 // [RQ2]
    flt_set[`TSFM_FLT_CABLE] = !red_interface_cable_i;          // [RQ11]
    flt_set[`TSFM_FLT_RF]    = |rf_trip;                        // [RQ17]
    // a power event restarts the watchdog count, so a stale trip must not re-set the flag
    flt_set[`TSFM_FLT_WD]    = wd_trip && !power_event;     // [RQ8]
    flt_set[`TSFM_FLT_CONF]  = conflict_i;
    flt_set[`TSFM_FLT_DUAL]  = dual_fail_i;
    flt_set[`TSFM_FLT_CLR]   = clear_fail_i;
    flt_set[`TSFM_FLT_DC]    = dc_supply_failure_i;
    flt_set[`TSFM_FLT_DIAG]  = diag_fail_i;
    flt_clr = {NF{rst_cmd}};                                    // [RQ16]
    flt_clr[`TSFM_FLT_WD] = rst_cmd || (power_event && !opt_i.wd_latch); // [RQ8] [RQ9]
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      flt <= '0;
    end else if (ce_i) begin
      flt <= flt_set | (flt & ~flt_clr);                        // [RQ2] [RQ16]
    end
  end

  // failed-channel capture and snapshot on fault entry
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      fail_ch      <= '0;
      cap          <= '0;
      fault_mode_d <= 1'b0;
    end else if (ce_i) begin
      fault_mode_d <= fault_mode;
      if (rst_cmd) begin
        fail_ch <= rf_trip;
      end else begin
        fail_ch <= fail_ch | rf_trip;
      end
      if (fault_mode && !fault_mode_d) begin
        cap <= '{red: red_q, yel: yel_q, grn: grn_q};           // [RQ3]
        if (flt[`TSFM_FLT_CONF]) begin
          fail_ch <= grn_q | yel_q;
        end
      end
    end
  end

  // indicators follow the fault flags and line; lamps live in normal mode, held in fault mode
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ind_o         <= '0;
      lamp_o        <= '0;
      force_flash_o <= 1'b0;
    end else if (ce_i) begin
      ind_o.power     <= !ac_low_i;                             // [RQ4]
      ind_o.dc_fail   <= flt[`TSFM_FLT_DC];
      ind_o.watchdog  <= flt[`TSFM_FLT_WD];
      ind_o.conflict  <= flt[`TSFM_FLT_CONF];
      ind_o.red_fail  <= flt[`TSFM_FLT_RF] | flt[`TSFM_FLT_CABLE];
      ind_o.dual      <= flt[`TSFM_FLT_DUAL];
      ind_o.clearance <= flt[`TSFM_FLT_CLR];
      ind_o.card_ajar <= flt[`TSFM_FLT_CARD];
      ind_o.diag      <= flt[`TSFM_FLT_DIAG];
      lamp_o <= fault_mode_d ? cap : tsfm_pkg::tsfm_lamp_type'({red_q, yel_q, grn_q}); // [RQ3]
      force_flash_o <= fault_mode;                              // [RQ11] [RQ17]
    end
  end

  // axi4-lite write: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TSFM_RESP_OKAY;
      rf_mask      <= `TSFM_RF_MASK_RST;
      sw_reset     <= 1'b0;
    end else if (ce_i) begin
      sw_reset <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_reg(aw_addr) ? `TSFM_RESP_OKAY : `TSFM_RESP_SLVERR;
        if (aw_addr == `TSFM_REG_CTRL && w_strb[0]) begin
          sw_reset <= w_data[`TSFM_CTRL_RESET];                 // [RQ9] [RQ16]
        end
        if (aw_addr == `TSFM_REG_RF_MASK) begin
          for (int b = 0; b < NC; b++) begin
            if (w_strb[b / 8]) begin
              rf_mask[b] <= w_data[b];
            end
          end
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `TSFM_RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= is_reg(s_axi_araddr) ? `TSFM_RESP_OKAY : `TSFM_RESP_SLVERR;
        case (s_axi_araddr)
          `TSFM_REG_FAULT:   s_axi_rdata <= 32'(flt);
          `TSFM_REG_FAIL_CH: s_axi_rdata <= 32'(fail_ch);
          `TSFM_REG_CAP_RED: s_axi_rdata <= 32'(cap.red);
          `TSFM_REG_CAP_YEL: s_axi_rdata <= 32'(cap.yel);
          `TSFM_REG_CAP_GRN: s_axi_rdata <= 32'(cap.grn);
          `TSFM_REG_RF_MASK: s_axi_rdata <= 32'(rf_mask);
          default:           s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_card_out;
    ce_i && !card_present_i;
  endsequence
  sequence s_card_back_reset;
    ce_i && card_present_i && rst_cmd;
  endsequence

  a_card_fault_set: assert property (s_card_out |=> flt[`TSFM_FLT_CARD]) // [RQ2]
    else $error("card absence did not latch a fault");
  a_card_fault_clr: assert property (
    s_card_back_reset |=> !flt[`TSFM_FLT_CARD] || !$past(card_present_i)) // [RQ2]
    else $error("card fault not released by reset with card present");
  a_fault_holds: assert property (
    (ce_i && flt[`TSFM_FLT_CABLE] && !rst_cmd) |=> flt[`TSFM_FLT_CABLE]) // [RQ16]
    else $error("cable fault dropped without reset");
  a_flash_follows: assert property (
    (ce_i && !red_interface_cable_i) ##1 ce_i |=> force_flash_o) // [RQ11]
    else $error("cable removal did not force flash");
  a_sf_blocks_rf: assert property ((|sf_q) |-> !rf_run) // [RQ12]
    else $error("red-fail monitoring ran under special function");
  a_relay_polarity: assert property (
    (ren_q && !(|sf_q) && (relay_common_input_i == opt_i.relay_inv)) |-> rf_run) // [RQ10]
    else $error("relay common polarity not honoured");
  a_rf_trip_time: assert property (
    (ce_i && tick && rf_cnt[0] == rf_lim - MW'(1) && rf_run && rf_enable_i[0] &&
     rf_mask[0] && !(red_q[0] | yel_q[0] | grn_q[0])) ##1 ce_i |=> flt[`TSFM_FLT_RF]) // [RQ17]
    else $error("red-fail did not trip at the limit");
  a_capture_held: assert property (
    (ce_i && fault_mode_d && fault_mode) |=> $stable(cap)) // [RQ3]
    else $error("capture changed during fault mode");
  a_wd_auto_clear: assert property (
    (ce_i && power_event && !opt_i.wd_latch && !rst_cmd) |=> !flt[`TSFM_FLT_WD]) // [RQ8]
    else $error("watchdog fault not cleared by power event");
  a_wd_latched: assert property (
    (ce_i && flt[`TSFM_FLT_WD] && opt_i.wd_latch && !rst_cmd) |=> flt[`TSFM_FLT_WD]) // [RQ9]
    else $error("latched watchdog fault dropped");
  a_bvalid_hold: assert property ((s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
    else $error("write response withdrawn early");
endmodule

// ### tsfm_field_model.sv
`timescale 1ns/10ps
module tsfm_field_model #(
  parameter int TOGGLE_CLKS = 500
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // scenario control
  input  wire logic [17:0] dark_i,
  input  wire logic [17:0] alt_i,
  input  wire logic [17:0] ysel_i,
  input  wire logic        wd_run_i,
  // field signals and controller heartbeat
  output logic      [17:0] red_o,
  output logic      [17:0] yel_o,
  output logic      [17:0] grn_o,
  output logic             watchdog_o
);
  int cnt;
  // one lit indication per channel, none on a dark channel
  assign red_o = ~dark_i & ~alt_i;
  assign yel_o = ~dark_i & alt_i & ysel_i;
  assign grn_o = ~dark_i & alt_i & ~ysel_i;
  // heartbeat keeps its level while the controller is stalled
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cnt        <= 0;
      watchdog_o <= 1'b0;
    end else if (wd_run_i) begin
      cnt <= (cnt == TOGGLE_CLKS - 1) ? 0 : cnt + 1;
      if (cnt == TOGGLE_CLKS - 1) begin
        watchdog_o <= ~watchdog_o;
      end
    end
  end
endmodule

// ### testbench.sv
`timescale 1ns/10ps
`include "tsfm_map.svh"
module testbench;
  localparam int CPM = 10;
  logic clock_i, rst_n_i, ce_i, red_enable_i, relay_common_input_i, card_present_i;
  logic red_interface_cable_i, ac_low_i, power_restore_i, front_reset_i, remote_reset_i;
  logic conflict_i, dual_fail_i, clear_fail_i, dc_supply_failure_i, diag_fail_i;
  logic watchdog_timer_i, force_flash_o, wd_run;
  logic [1:0]  special_func_i, s_axi_bresp, s_axi_rresp;
  logic [17:0] red_i, yel_i, grn_i, rf_enable_i, dark, alt, ysel, mask;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [4:0]  cause;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  tsfm_pkg::tsfm_opt_type  opt_i;
  tsfm_pkg::tsfm_ind_type  ind_o;
  tsfm_pkg::tsfm_lamp_type lamp_o;
  logic [33:0] exp_q[$];
  int          err_count, cmp_count, ch, k, seed;

  assign {diag_fail_i, dc_supply_failure_i, clear_fail_i, dual_fail_i, conflict_i} = cause;
  tsfm_monitor #(.CLKS_PER_MS(CPM)) tsfm_monitor_inst (.*);
  tsfm_field_model #(.TOGGLE_CLKS(50 * CPM)) tsfm_field_model_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .dark_i(dark), .alt_i(alt), .ysel_i(ysel),
    .wd_run_i(wd_run), .red_o(red_i), .yel_o(yel_i), .grn_o(grn_i),
    .watchdog_o(watchdog_timer_i));

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ms(input int n);
    repeat (n * CPM) @(negedge clock_i);
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic haw, hw, hb;
    hb = 1'b0;
    exp_q.push_back({r, 32'h0});
    @(posedge clock_i);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!hb) begin
      @(negedge clock_i);
      haw = s_axi_awvalid && s_axi_awready;
      hw  = s_axi_wvalid && s_axi_wready;
      hb  = s_axi_bvalid;
      @(posedge clock_i);
      if (haw) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) s_axi_bready <= 1'b0;
    end
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic har, hr;
    hr = 1'b0;
    exp_q.push_back({r, d});
    @(posedge clock_i);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!hr) begin
      @(negedge clock_i);
      har = s_axi_arvalid && s_axi_arready;
      hr  = s_axi_rvalid;
      @(posedge clock_i);
      if (har) s_axi_arvalid <= 1'b0;
      if (hr) s_axi_rready <= 1'b0;
    end
  endtask
  task automatic cmd(input logic front);
    @(posedge clock_i);
    front_reset_i  <= front;
    remote_reset_i <= !front;
    @(posedge clock_i);
    front_reset_i  <= 1'b0;
    remote_reset_i <= 1'b0;
    repeat (3) @(negedge clock_i);
  endtask
  task automatic restore();
    @(posedge clock_i);
    wd_run          <= 1'b1;
    power_restore_i <= 1'b1;
    @(posedge clock_i);
    power_restore_i <= 1'b0;
    repeat (3) @(negedge clock_i);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  initial begin
    #10000000;
    err_count++;
    complete_run();
  end
  // answers are matched against the oldest noted expectation
  initial forever begin
    @(negedge clock_i);
    if (s_axi_rvalid && s_axi_rready)
      chk("rdata", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      chk("bresp", {s_axi_bresp, 32'h0}, exp_q.pop_front());
  end

  initial begin
    seed = 32'hB0A6D8FB;
    alt = 18'($random(seed));
    ysel = 18'($random(seed));
    ch = int'($unsigned($random(seed)) % 18);
    mask = 18'h1 << ch;
    {rst_n_i, ac_low_i, power_restore_i, front_reset_i, remote_reset_i} = '0;
    {ce_i, red_enable_i, card_present_i, red_interface_cable_i, wd_run} = '1;
    {relay_common_input_i, special_func_i, cause, dark, opt_i} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    rf_enable_i = '1;
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    axr(`TSFM_REG_RF_MASK, {14'h0, `TSFM_RF_MASK_RST}, `TSFM_RESP_OKAY);
    axr(`TSFM_REG_FAULT, 32'h0, `TSFM_RESP_OKAY);
    axr(8'h1C, 32'h0, `TSFM_RESP_SLVERR);
    axw(8'h1C, 32'hFFFFFFFF, `TSFM_RESP_SLVERR);
    ms(600);
    chk("power", ind_o.power, 1'b1);
    chk("lamps", lamp_o, {~alt, alt & ysel, alt & ~ysel});
    @(posedge clock_i);
    dark <= mask;
    ms(800);
    chk("flash_early", force_flash_o, 1'b0);
    ms(100);
    chk("red_fail", {ind_o.red_fail, force_flash_o}, 2'b11);
    axr(`TSFM_REG_FAIL_CH, {14'h0, mask}, `TSFM_RESP_OKAY);
    axr(`TSFM_REG_CAP_RED, {14'h0, ~alt & ~mask}, `TSFM_RESP_OKAY);
    @(posedge clock_i);
    dark <= '0;
    ms(600);
    chk("held", ind_o.red_fail, 1'b1);
    chk("snap", lamp_o, {~alt & ~mask, alt & ysel & ~mask, alt & ~ysel & ~mask});
    cmd(1'b1);
    chk("cleared", {ind_o.red_fail, force_flash_o}, 2'b00);
    for (k = 0; k < 2; k++) begin
      @(posedge clock_i);
      dark <= mask;
      special_func_i <= (k == 0) ? 2'b01 : 2'b00;
      opt_i.relay_inv <= (k == 1);
      ms(1000);
      chk("suppressed", ind_o.red_fail, 1'b0);
      @(posedge clock_i);
      dark <= '0;
      special_func_i <= 2'b00;
      opt_i.relay_inv <= 1'b0;
      ms(600);
    end
    @(posedge clock_i);
    card_present_i <= 1'b0;
    repeat (3) @(negedge clock_i);
    chk("card", {ind_o.card_ajar, force_flash_o}, 2'b11);
    cmd(1'b1);
    chk("card_held", ind_o.card_ajar, 1'b1);
    @(posedge clock_i);
    card_present_i <= 1'b1;
    cmd(1'b0);
    chk("card_clr", {ind_o.card_ajar, force_flash_o}, 2'b00);
    @(posedge clock_i);
    red_interface_cable_i <= 1'b0;
    ms(1);
    axr(`TSFM_REG_FAULT, 32'h2, `TSFM_RESP_OKAY);
    chk("cable", force_flash_o, 1'b1);
    @(posedge clock_i);
    red_interface_cable_i <= 1'b1;
    axw(`TSFM_REG_CTRL, 32'h1, `TSFM_RESP_OKAY);
    ms(1);
    chk("cable_clr", force_flash_o, 1'b0);
    for (k = 0; k < 5; k++) begin
      @(posedge clock_i);
      cause <= 5'h1 << k;
      @(posedge clock_i);
      cause <= 5'h0;
      axr(`TSFM_REG_FAULT, 32'h10 << k, `TSFM_RESP_OKAY);
      if (k == 0) axr(`TSFM_REG_FAIL_CH, {14'h0, alt}, `TSFM_RESP_OKAY);
      cmd(k[0]);
    end
    @(posedge clock_i);
    opt_i.wd_short <= 1'b1;
    wd_run <= 1'b0;
    rf_enable_i[ch] <= 1'b0;
    dark <= mask;
    ms(900);
    chk("wd_early", ind_o.watchdog, 1'b0);
    ms(200);
    chk("wd", ind_o.watchdog, 1'b1);
    chk("rf_off", ind_o.red_fail, 1'b0);
    restore();
    chk("wd_auto", ind_o.watchdog, 1'b0);
    @(posedge clock_i);
    opt_i.wd_latch <= 1'b1;
    wd_run <= 1'b0;
    ms(1100);
    restore();
    ms(100);
    chk("wd_latched", ind_o.watchdog, 1'b1);
    cmd(1'b1);
    chk("wd_clr", ind_o.watchdog, 1'b0);
    // short line dip is no brown-out, a long one clears an unlatched watchdog fault
    @(posedge clock_i);
    opt_i.wd_latch <= 1'b0;
    wd_run <= 1'b0;
    ms(1100);
    @(posedge clock_i);
    ac_low_i <= 1'b1;
    ms(50);
    chk("power_low", ind_o.power, 1'b0);
    @(posedge clock_i);
    ac_low_i <= 1'b0;
    ms(1);
    chk("bo_short", ind_o.watchdog, 1'b1);
    @(posedge clock_i);
    ac_low_i <= 1'b1;
    ms(100);
    @(posedge clock_i);
    ac_low_i <= 1'b0;
    wd_run <= 1'b1;
    ms(1);
    chk("bo_clear", ind_o.watchdog, 1'b0);
    complete_run();
  end
endmodule
